// *** rtl/cfg_osc_pkg.sv ***
// Constants, register map and carrier types for the configuration decode block.
// Assumes a single 40 MHz core clock; the watchdog RC tick arrives as a pin.
package cfg_osc_pkg;

   // Configuration word
   localparam int          CFG_W          = 12;
   localparam logic [11:0] CFG_ERASED     = 12'h0FFF;

   // Narrow (8-pin) field positions
   localparam int          N_OSC_LSB      = 0;
   localparam int          N_WDT_BIT      = 2;
   localparam int          N_CP_BIT       = 3;
   localparam int          N_MASTER_CLEAR_INPUT_BIT     = 4;
   localparam int          N_SPD_BIT      = 5;
   localparam int          N_TOP_LSB      = 6;

   // Wide (14-pin) field positions
   localparam int          W_OSC_LSB      = 0;
   localparam int          W_WDT_BIT      = 3;
   localparam int          W_CP_BIT       = 4;
   localparam int          W_MASTER_CLEAR_INPUT_BIT     = 5;
   localparam int          W_SPD_BIT      = 6;
   localparam int          W_TOP_LSB      = 7;

   // Oscillator mode codes, wide field
   localparam logic [2:0]  OSC_LP         = 3'h0;
   localparam logic [2:0]  OSC_XT         = 3'h1;
   localparam logic [2:0]  OSC_HS         = 3'h2;
   localparam logic [2:0]  OSC_EC         = 3'h3;
   localparam logic [2:0]  OSC_INT_IO     = 3'h4;
   localparam logic [2:0]  OSC_INT_CKO    = 3'h5;
   localparam logic [2:0]  OSC_RC_IO      = 3'h6;
   localparam logic [2:0]  OSC_RC_CKO     = 3'h7;

   // Reset timer delays in microseconds (long) or nanoseconds (short) and in watchdog RC ticks
   localparam int          DRT_LONG_US    = 18000;
   localparam int          DRT_SHORT_NS   = 1125000;
   localparam int          WDT_TICK_NS    = 1000;
   localparam int          DRT_LONG_TICKS = (DRT_LONG_US * 1000) / WDT_TICK_NS;
   localparam int          DRT_SHORT_TICKS = DRT_SHORT_NS / WDT_TICK_NS;
   localparam int          DRT_CNT_W      = 15;

   // Wishbone register map (byte addresses)
   localparam logic [7:0]  ADR_CFG        = 8'h00;
   localparam logic [7:0]  ADR_STATUS     = 8'h04;
   localparam logic [7:0]  ADR_CTRL       = 8'h08;

   // Status bit positions
   localparam int          ST_RST_HELD    = 0;
   localparam int          ST_WDT_ON      = 1;
   localparam int          ST_PROTECT     = 2;
   localparam int          ST_SPD_8M      = 3;
   localparam int          ST_MASTER_CLEAR_INPUT_FN     = 4;
   localparam int          ST_CKO         = 5;
   localparam int          ST_EXT_CLK_OK  = 6;
   localparam int          ST_SLEEP       = 7;
   localparam int          ST_MODE_LSB    = 8;

   // Control bit positions
   localparam int          CT_SLEEP_REQ   = 0;
   localparam int          CT_WDT_OFF_REQ = 1;

   typedef struct packed {
      logic [2:0] osc_mode;
      logic       internal_osc_speed_select;
      logic       master_clear_pin_enable;
      logic       code_protect_bit;
      logic       watchdog_enable_fuse;
      logic       clock_output_function;
      logic       long_drt;
   } cfg_dec_s;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_s;

endpackage : cfg_osc_pkg

// *** rtl/cfg_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to I_CORE_CLK.
`timescale 1ns/10ps
module cfg_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Change accepted once stages two and three agree
   genvar g;
   for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            o_level[g] <= 1'b0;
         end else if (s2[g] == s3[g]) begin
            o_level[g] <= s3[g];
         end
      end
   end
endmodule : cfg_pin_sync

// *** rtl/cfg_osc_reset_select.sv ***
// Configuration word decode, reset timer and sleep wake for the core.
// Assumes a 40 MHz core clock, a watchdog RC tick pin and a Wishbone master.
`timescale 1ns/10ps
module cfg_osc_reset_select
   import cfg_osc_pkg::*;
#(
   parameter bit WIDE_VARIANT = 1'b1,
   parameter int WAKE_PINS    = 6,
   parameter int LONG_TICKS   = DRT_LONG_TICKS,
   parameter int SHORT_TICKS  = DRT_SHORT_TICKS,
   parameter int WDT_TICKS    = 18000
) (
   // Clock and reset
   input  wire logic                 I_CORE_CLK,
   input  wire logic                 I_RST,
   // Programmed configuration word and power-up marker
   input  wire logic [CFG_W-1:0]     I_CFG_WORD,
   input  wire logic                 I_POWER_UP,
   // Pins
   input  wire logic                 I_WDT_RC_TICK,
   input  wire logic                 I_MASTER_CLEAR_INPUT_N,
   input  wire logic [WAKE_PINS-1:0] I_WAKE_PINS,
   // Wishbone slave
   input  wire logic                 I_WB_CYC,
   input  wire logic                 I_WB_STB,
   input  wire logic                 I_WB_WE,
   input  wire logic [3:0]           I_WB_SEL,
   input  wire logic [7:0]           I_WB_ADR,
   input  wire logic [31:0]          I_WB_DAT,
   output logic      [31:0]          O_WB_DAT,
   output logic                      O_WB_ACK,
   // Decoded controls
   output logic                      O_CORE_RESET,
   output logic                      O_SPEED_8M,
   output logic                      O_SHARED_RESET_PIN_IO,
   output logic                      O_CODE_PROTECT,
   output logic                      O_WATCHDOG_ON,
   output logic                      O_WATCHDOG_TIMEOUT,
   output logic                      O_CLOCK_OUT_EN,
   output logic                      O_SECOND_OSC_PIN_IO,
   output logic                      O_OSC1_EXT_CLK_OK,
   output logic                      O_SLEEPING,
   output logic [2:0]                O_OSC_MODE
);
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_RUN  = 3'b010,
      ST_NAP  = 3'b100
   } core_e;

   core_e            state;
   core_e            next_state;
   logic [CFG_W-1:0] cfg_word;
   cfg_dec_s         dec;
   cfg_dec_s         next_dec;
   logic             cfg_loaded;
   logic             cfg_fresh;
   logic             tick_lvl;
   logic             tick_q;
   logic             tick_pulse;
   logic             master_clear_input_n_lvl;
   logic [WAKE_PINS-1:0] wake_lvl;
   logic [WAKE_PINS-1:0] wake_q;
   logic             pin_change;
   logic [DRT_CNT_W-1:0] drt_cnt;
   logic [DRT_CNT_W-1:0] wdt_cnt;
   logic             wdt_timeout;
   logic             master_clear_input_active;
   logic             pwr_q;
   logic             pwr_rise;
   logic             sleep_req;
   logic             wb_hit;
   logic [31:0]      next_rdata;

   // Pin synchronisers
   cfg_pin_sync #(.W(WAKE_PINS + 2)) u_sync (
      .clk     (I_CORE_CLK),
      .rst     (I_RST),
      .i_pin   ({I_WAKE_PINS, I_MASTER_CLEAR_INPUT_N, I_WDT_RC_TICK}),
      .o_level ({wake_lvl, master_clear_input_n_lvl, tick_lvl})
   );

   // Word captured after reset release; unimplemented bits forced to one
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         cfg_word   <= CFG_ERASED;
         cfg_loaded <= 1'b0;
         cfg_fresh  <= 1'b0;
      end else begin
         // High in the first cycle whose decode reflects the captured word
         cfg_fresh <= !cfg_loaded;
         if (!cfg_loaded) begin
            cfg_word   <= I_CFG_WORD;
            if (WIDE_VARIANT) begin
               cfg_word[CFG_W-1:W_TOP_LSB] <= '1;
            end else begin
               cfg_word[CFG_W-1:N_TOP_LSB] <= '1;
            end
            cfg_loaded <= 1'b1;
         end
      end
   end

   // Field decode
   always_comb begin
      next_dec = '0;
      if (WIDE_VARIANT) begin
         next_dec.osc_mode = cfg_word[W_OSC_LSB +: 3];
         next_dec.internal_osc_speed_select = cfg_word[W_SPD_BIT];
         next_dec.master_clear_pin_enable   = cfg_word[W_MASTER_CLEAR_INPUT_BIT];
         next_dec.code_protect_bit          = cfg_word[W_CP_BIT];
         next_dec.watchdog_enable_fuse      = cfg_word[W_WDT_BIT];
      end else begin
         // Narrow codes map onto LP, XT, internal RC, external RC
         unique case (cfg_word[N_OSC_LSB +: 2])
            2'h0:    next_dec.osc_mode = OSC_LP;
            2'h1:    next_dec.osc_mode = OSC_XT;
            2'h2:    next_dec.osc_mode = OSC_INT_IO;
            default: next_dec.osc_mode = OSC_RC_IO;
         endcase
         next_dec.internal_osc_speed_select = cfg_word[N_SPD_BIT];
         next_dec.master_clear_pin_enable   = cfg_word[N_MASTER_CLEAR_INPUT_BIT];
         next_dec.code_protect_bit          = cfg_word[N_CP_BIT];
         next_dec.watchdog_enable_fuse      = cfg_word[N_WDT_BIT];
      end
      next_dec.clock_output_function = (next_dec.osc_mode == OSC_INT_CKO) ||
                                       (next_dec.osc_mode == OSC_RC_CKO);
      next_dec.long_drt = (next_dec.osc_mode == OSC_LP) ||
                          (next_dec.osc_mode == OSC_XT) ||
                          (next_dec.osc_mode == OSC_HS);
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         dec <= '0;
      end else begin
         dec <= next_dec;
      end
   end

   // Watchdog tick edge from its own RC oscillator
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tick_q <= 1'b0;
         wake_q <= '0;
         pwr_q  <= 1'b0;
      end else begin
         tick_q <= tick_lvl;
         wake_q <= wake_lvl;
         pwr_q  <= I_POWER_UP;
      end
   end
   assign tick_pulse  = tick_lvl & ~tick_q;
   assign pin_change  = |(wake_lvl ^ wake_q);
   assign pwr_rise    = I_POWER_UP & ~pwr_q;
   assign master_clear_input_active = dec.master_clear_pin_enable & ~master_clear_input_n_lvl;

   // Watchdog counter; only the fuse or the ST_HOLD state can stop it
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         wdt_cnt     <= '0;
         wdt_timeout <= 1'b0;
      end else begin
         wdt_timeout <= 1'b0;
         if (!dec.watchdog_enable_fuse || state == ST_HOLD) begin
            wdt_cnt <= '0;
         end else if (tick_pulse) begin
            if (wdt_cnt == DRT_CNT_W'(WDT_TICKS - 1)) begin
               wdt_cnt     <= '0;
               wdt_timeout <= 1'b1;
            end else begin
               wdt_cnt <= wdt_cnt + 1'b1;
            end
         end
      end
   end

   // Core state: hold in reset while the reset timer runs
   always_comb begin
      next_state = state;
      unique case (state)
         ST_HOLD: if (cfg_loaded && !cfg_fresh && drt_cnt == '0 && !master_clear_input_active &&
                      tick_pulse) next_state = ST_RUN;
         ST_RUN: begin
            if (master_clear_input_active || wdt_timeout) next_state = ST_HOLD;
            else if (sleep_req) next_state = ST_NAP;
         end
         ST_NAP: if (pin_change || wdt_timeout || master_clear_input_active)
                    next_state = ST_HOLD;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Reset timer load: crystal modes always, others only at power-up
   // The start-up load waits for cfg_fresh, so the erased word never picks the delay
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         drt_cnt <= '0;
      end else if (cfg_fresh || state == ST_RUN && next_state == ST_HOLD ||
                   state == ST_NAP && next_state == ST_HOLD || pwr_rise) begin
         if (next_dec.long_drt) begin
            drt_cnt <= DRT_CNT_W'(LONG_TICKS);
         end else if (cfg_fresh || pwr_rise) begin
            drt_cnt <= DRT_CNT_W'(SHORT_TICKS);
         end else begin
            drt_cnt <= '0;
         end
      end else if (state == ST_HOLD && tick_pulse && drt_cnt != '0) begin
         drt_cnt <= drt_cnt - 1'b1;
      end
   end

   // Wishbone slave: one registered ack per request, a cycle after the strobe
   assign wb_hit = I_WB_CYC & I_WB_STB & ~O_WB_ACK;

   always_comb begin
      next_rdata = '0;
      unique case (I_WB_ADR)
         ADR_CFG:    next_rdata[CFG_W-1:0] = cfg_word;
         ADR_STATUS: begin
            next_rdata[ST_RST_HELD]   = (state == ST_HOLD);
            next_rdata[ST_WDT_ON]     = dec.watchdog_enable_fuse;
            next_rdata[ST_PROTECT]    = ~dec.code_protect_bit;
            next_rdata[ST_SPD_8M]     = dec.internal_osc_speed_select;
            next_rdata[ST_MASTER_CLEAR_INPUT_FN]    = dec.master_clear_pin_enable;
            next_rdata[ST_CKO]        = dec.clock_output_function;
            next_rdata[ST_EXT_CLK_OK] = dec.long_drt;
            next_rdata[ST_SLEEP]      = (state == ST_NAP);
            next_rdata[ST_MODE_LSB +: 3] = dec.osc_mode;
         end
         ADR_CTRL:   next_rdata[CT_SLEEP_REQ] = 1'b0;
         default:    next_rdata = '0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_WB_ACK  <= 1'b0;
         O_WB_DAT  <= '0;
         sleep_req <= 1'b0;
      end else begin
         O_WB_ACK  <= wb_hit;
         sleep_req <= 1'b0;
         if (wb_hit) begin
            O_WB_DAT <= I_WB_WE ? '0 : next_rdata;
            // Watchdog-off request is accepted but has no effect
            if (I_WB_WE && I_WB_ADR == ADR_CTRL && I_WB_SEL[0]) begin
               sleep_req <= I_WB_DAT[CT_SLEEP_REQ] & (state == ST_RUN);
            end
         end
      end
   end

   // Outputs
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CORE_RESET          <= 1'b1;
         O_SPEED_8M            <= 1'b0;
         O_SHARED_RESET_PIN_IO <= 1'b0;
         O_CODE_PROTECT        <= 1'b0;
         O_WATCHDOG_ON         <= 1'b0;
         O_WATCHDOG_TIMEOUT    <= 1'b0;
         O_CLOCK_OUT_EN        <= 1'b0;
         O_SECOND_OSC_PIN_IO   <= 1'b0;
         O_OSC1_EXT_CLK_OK     <= 1'b0;
         O_SLEEPING            <= 1'b0;
         O_OSC_MODE            <= '0;
      end else begin
         O_CORE_RESET          <= (next_state == ST_HOLD);
         O_SPEED_8M            <= dec.internal_osc_speed_select;
         O_SHARED_RESET_PIN_IO <= ~dec.master_clear_pin_enable;
         O_CODE_PROTECT        <= ~dec.code_protect_bit;
         O_WATCHDOG_ON         <= dec.watchdog_enable_fuse;
         O_WATCHDOG_TIMEOUT    <= wdt_timeout;
         O_CLOCK_OUT_EN        <= dec.clock_output_function;
         O_SECOND_OSC_PIN_IO   <= (dec.osc_mode == OSC_EC) ||
                                  (dec.osc_mode == OSC_INT_IO) ||
                                  (dec.osc_mode == OSC_RC_IO);
         O_OSC1_EXT_CLK_OK     <= dec.long_drt || dec.osc_mode == OSC_EC;
         O_SLEEPING            <= (next_state == ST_NAP);
         O_OSC_MODE            <= dec.osc_mode;
      end
   end

   // Checks
   a_cfg_top_ones: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      cfg_loaded |-> (WIDE_VARIANT ? &cfg_word[CFG_W-1:W_TOP_LSB]
                                   : &cfg_word[CFG_W-1:N_TOP_LSB]))
      else $error("upper config bits not one");
   a_speed_follow: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      ##2 O_SPEED_8M == $past(dec.internal_osc_speed_select))
      else $error("speed output wrong");
   a_master_clear_input_ignored: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (state == ST_RUN && !dec.master_clear_pin_enable && !wdt_timeout && !sleep_req)
      |=> state == ST_RUN)
      else $error("reset pin acted while disabled");
   a_protect_inv: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $past(cfg_loaded, 3) |-> O_CODE_PROTECT != $past(dec.code_protect_bit))
      else $error("protect polarity wrong");
   a_wdt_off_quiet: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !dec.watchdog_enable_fuse |=> !wdt_timeout)
      else $error("watchdog fired while fused off");
   a_wdt_rc_only: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !tick_pulse && dec.watchdog_enable_fuse && state != ST_HOLD |=> $stable(wdt_cnt))
      else $error("watchdog advanced without its tick");
   a_long_delay: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (state == ST_RUN && next_state == ST_HOLD && next_dec.long_drt)
      |=> drt_cnt == DRT_CNT_W'(LONG_TICKS))
      else $error("crystal mode skipped reset delay");
   a_start_long: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (cfg_fresh && next_dec.long_drt) |=> drt_cnt == DRT_CNT_W'(LONG_TICKS))
      else $error("crystal mode start-up skipped long delay");
   a_short_none: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (state == ST_RUN && next_state == ST_HOLD && !next_dec.long_drt && !pwr_rise)
      |=> drt_cnt == '0)
      else $error("RC mode applied delay outside power-up");
   a_wake_sleep: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (state == ST_NAP && pin_change) |=> state == ST_HOLD)
      else $error("pin change did not wake");
   a_hold_timer: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      (state == ST_HOLD && drt_cnt != '0) |=> state == ST_HOLD)
      else $error("reset released before timer expired");
   a_clock_output_function_dec: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      dec.clock_output_function |-> dec.osc_mode[0] && dec.osc_mode[2])
      else $error("clock-out on even code");
endmodule : cfg_osc_reset_select

// *** bench/cfg_osc_reset_select_tb_top.sv ***
// Self-checking bench for the configuration decode block, both variants side by side.
// Assumes the package constants and a 1-cycle registered Wishbone answer.
`timescale 1ns/10ps
module cfg_osc_reset_select_tb_top;
   import cfg_osc_pkg::*;
   localparam int TMO = 90000;
   logic        clk = 1'b0, rst = 1'b1, pwr = 1'b1, tick = 1'b0, master_clear_input_n = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] word = 12'h000;
   logic [5:0]  wake = 6'h00;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] dat_w, dat_n, rd_w, rd_n;
   logic        ack_w, crst_w, crst_n, spd_w, spd_n, io_w, io_n, cp_w, cp_n, wd_w, wd_n;
   logic        wto, cko, osc2io, extok, slp;
   logic        ack_n, wto_n, cko_n, osc2io_n, extok_n, slp_n;
   logic [3:0]  sel = 4'hF;
   logic [2:0]  mode_w, mode_n, c;
   int          fails = 0, check_count = 0, cycles = 0, k, n;

   always #12.5 clk = ~clk;

   // Watchdog RC ticks every four core cycles, plus the run limit
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles % 2 == 1) tick <= ~tick;
      if (cycles == TMO) begin
         fails++;
         conclude();
      end
   end

   // Wide variant by default; watchdog keeps its default tick count
   cfg_osc_reset_select #(.LONG_TICKS(20), .SHORT_TICKS(5)) cfg_osc_reset_select_i (
      .I_CORE_CLK(clk), .I_RST(rst), .I_CFG_WORD(word), .I_POWER_UP(pwr),
      .I_WDT_RC_TICK(tick), .I_MASTER_CLEAR_INPUT_N(master_clear_input_n), .I_WAKE_PINS(wake),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr),
      .I_WB_DAT(wdat), .O_WB_DAT(dat_w), .O_WB_ACK(ack_w), .O_CORE_RESET(crst_w),
      .O_SPEED_8M(spd_w), .O_SHARED_RESET_PIN_IO(io_w), .O_CODE_PROTECT(cp_w),
      .O_WATCHDOG_ON(wd_w), .O_WATCHDOG_TIMEOUT(wto), .O_CLOCK_OUT_EN(cko),
      .O_SECOND_OSC_PIN_IO(osc2io), .O_OSC1_EXT_CLK_OK(extok), .O_SLEEPING(slp),
      .O_OSC_MODE(mode_w));

   // Narrow variant shares every input
   cfg_osc_reset_select #(.WIDE_VARIANT(1'b0), .LONG_TICKS(20), .SHORT_TICKS(5))
      cfg_osc_reset_select_n_i (
      .I_CORE_CLK(clk), .I_RST(rst), .I_CFG_WORD(word), .I_POWER_UP(pwr),
      .I_WDT_RC_TICK(tick), .I_MASTER_CLEAR_INPUT_N(master_clear_input_n), .I_WAKE_PINS(wake),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr),
      .I_WB_DAT(wdat), .O_WB_DAT(dat_n), .O_WB_ACK(ack_n), .O_CORE_RESET(crst_n),
      .O_SPEED_8M(spd_n), .O_SHARED_RESET_PIN_IO(io_n), .O_CODE_PROTECT(cp_n),
      .O_WATCHDOG_ON(wd_n), .O_WATCHDOG_TIMEOUT(wto_n), .O_CLOCK_OUT_EN(cko_n),
      .O_SECOND_OSC_PIN_IO(osc2io_n), .O_OSC1_EXT_CLK_OK(extok_n), .O_SLEEPING(slp_n),
      .O_OSC_MODE(mode_n));

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Classic single cycle; read data of both variants taken at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int m;
      m = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // Waits for the answer; only the run limit ends a hang
      do begin
         @(posedge clk);
         m++;
      end while (ack_w !== 1'b1);
      rd_w = dat_w;
      rd_n = dat_n;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      chk(32'(ack_n), 32'h0000_0001);
      chk(32'(m), 32'h0000_0002);
   endtask : wb

   task automatic restart(input logic [11:0] w);
      @(posedge clk);
      rst <= 1'b1; pwr <= 1'b1; word <= w;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      pwr <= 1'b0;
   endtask : restart

   // Bounded wait until both cores leave reset
   task automatic wait_run();
      n = 0;
      while ((crst_w !== 1'b0 || crst_n !== 1'b0) && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 300), 32'h1);
      repeat (4) @(posedge clk);
   endtask : wait_run

   initial begin
      repeat (10) @(posedge clk);
      for (k = 0; k < 8; k++) begin
         c = k[2:0];
         restart({5'h00, ~c[0], c[1], c[0], ~c[1], c});
         repeat (58) @(posedge clk);
         chk(32'(crst_w), 32'(c <= 3'h2));
         chk(32'(crst_n), 32'(!c[1]));
         wait_run();
         chk(32'(mode_w), 32'(c));
         chk(32'(cko), 32'(c == 3'h5 || c == 3'h7));
         chk(32'(osc2io), 32'(c == 3'h3 || c == 3'h4 || c == 3'h6));
         chk(32'(extok), 32'(c <= 3'h3));
         chk(32'(spd_w), 32'(word[W_SPD_BIT]));
         chk(32'(io_w), 32'(!word[W_MASTER_CLEAR_INPUT_BIT]));
         chk(32'(cp_w), 32'(!word[W_CP_BIT]));
         chk(32'(wd_w), 32'(word[W_WDT_BIT]));
         chk(32'(mode_n), 32'({c[1], c[1] & c[0], c[0] & ~c[1]}));
         chk(32'(spd_n), 32'(word[N_SPD_BIT]));
         chk(32'(io_n), 32'(!word[N_MASTER_CLEAR_INPUT_BIT]));
         chk(32'(cp_n), 32'(!word[N_CP_BIT]));
         chk(32'(wd_n), 32'(word[N_WDT_BIT]));
         chk(32'(osc2io_n), 32'(c[1]));
         chk(32'(cko_n), 32'h0000_0000);
         chk(32'(extok_n), 32'(!c[1]));
         wb(1'b0, ADR_CFG, 32'h0000_0000);
         chk(rd_w, {20'h0_0000, 5'h1F, word[6:0]});
         chk(rd_n, {20'h0_0000, 6'h3F, word[5:0]});
         wb(1'b0, ADR_STATUS, 32'h0000_0000);
         chk(32'(rd_w[10:8]), 32'(c));
         chk(32'(rd_w[3:0]), 32'({word[W_SPD_BIT], !word[W_CP_BIT], word[W_WDT_BIT], 1'b0}));
         wb(1'b1, ADR_CTRL, 32'h0000_0002);
         wb(1'b0, ADR_CTRL, 32'h0000_0000);
         chk(rd_w, 32'h0000_0000);
         chk(32'(wd_w), 32'(word[W_WDT_BIT]));
         wb(1'b0, 8'h0C, 32'h0000_0000);
         chk(rd_w, 32'h0000_0000);
         @(posedge clk);
         master_clear_input_n <= 1'b0;
         repeat (10) @(posedge clk);
         chk(32'(crst_w), 32'(word[W_MASTER_CLEAR_INPUT_BIT]));
         chk(32'(crst_n), 32'(word[N_MASTER_CLEAR_INPUT_BIT]));
         master_clear_input_n <= 1'b1;
         wait_run();
      end
      // Sleep request with byte lane 0 off is ignored
      sel <= 4'hE;
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      sel <= 4'hF;
      repeat (3) @(posedge clk);
      chk(32'(slp), 32'h0000_0000);
      // Sleep left on a pin change
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(32'(slp), 32'h1);
      chk(32'(slp_n), 32'h0000_0001);
      wake <= 6'h04;
      repeat (12) @(posedge clk);
      chk(32'(slp), 32'h0);
      chk(32'(slp_n), 32'h0000_0000);
      wait_run();
      // Sleep left on a watchdog timeout, counted on the RC ticks
      restart(12'h00A);
      wait_run();
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      n = 0;
      while (wto !== 1'b1 && n < 80000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n > 71000 && n < 80000), 32'h1);
      repeat (6) @(posedge clk);
      chk(32'(slp), 32'h0);
      chk(32'(slp_n), 32'h0000_0001);
      chk(32'(wto_n), 32'h0000_0000);
      conclude();
   end
endmodule : cfg_osc_reset_select_tb_top
